// ===== wstt_defines.svh
// Constants for the write strobe and training spacing controller.
// Assumes a 20 MHz system clock and a divided memory clock.
`ifndef WSTT_DEFINES_SVH
`define WSTT_DEFINES_SVH
// Register byte offsets
`define WSTT_CTRL_OFF 8'h00
`define WSTT_SKEW_OFF 8'h04
`define WSTT_CMD_OFF  8'h08
`define WSTT_STAT_OFF 8'h0C
// Control fields and reset
`define WSTT_C_MODE 0
`define WSTT_C_BL32 1
`define WSTT_C_ODT  2
`define WSTT_C_BAND 3
`define WSTT_C_SETB 6
`define WSTT_C_CKE  7
`define WSTT_CTRL_RST 8'h00
// Skew register nibbles and reset
`define WSTT_S_DQSCK 0
`define WSTT_S_DQSS  4
`define WSTT_S_RPST  8
`define WSTT_S_WPRE  12
`define WSTT_S_ODTL  16
`define WSTT_S_ODTON 20
`define WSTT_S_WTR   24
`define WSTT_S_TA    28
`define WSTT_SKEW_RST 32'h1412_2012
// Status fields
`define WSTT_ST_BUSY 0
`define WSTT_ST_REF  1
`define WSTT_ST_TRN  2
`define WSTT_ST_DQT  3
`define WSTT_ST_DQC  4
`define WSTT_ST_EXM  5
// Bus answers
`define WSTT_RESP_OK  2'h0
`define WSTT_RESP_ERR 2'h2
// Timing
`define WSTT_CLK_PS   50000
`define WSTT_T75_PS   7500
`define WSTT_T75_MIN  8
`define WSTT_BL2_16   10'h008
`define WSTT_BL2_32   10'h010
`define WSTT_BL32_ADD 10'h008
`define WSTT_SAT      8'hFF
// Band rows: RL, WL, nWR, nRTP, strobe on max, strobe off min
`define WSTT_F_RL  40
`define WSTT_F_WL  32
`define WSTT_F_NWR 24
`define WSTT_F_RTP 16
`define WSTT_F_ON  8
`define WSTT_F_OFF 0
`define WSTT_A0 48'h0604_0608_000F
`define WSTT_A1 48'h0A06_0A08_0012
`define WSTT_A2 48'h0E08_1008_0015
`define WSTT_A3 48'h140A_1408_0418
`define WSTT_A4 48'h180C_180A_041B
`define WSTT_A5 48'h1C0E_1E0C_061E
`define WSTT_A6 48'h2010_220E_0621
`define WSTT_A7 48'h2412_2810_0824
`define WSTT_B0 48'h0604_0608_000F
`define WSTT_B1 48'h0C08_0A08_0014
`define WSTT_B2 48'h100C_1008_0619
`define WSTT_B3 48'h1612_1408_0C20
`define WSTT_B4 48'h1C16_180A_0E25
`define WSTT_B5 48'h201A_1E0C_122A
`define WSTT_B6 48'h241E_220E_142F
`define WSTT_B7 48'h2822_2810_1834
`endif

// ===== wstt_pkg.sv
// Types for the write strobe and training spacing controller.
// Assumes the defines header is compiled alongside.
package wstt_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } wstt_state_t;
    typedef enum logic [3:0] {
        CMD_NOP   = 4'h0,
        CMD_WR    = 4'h1,
        CMD_MWR   = 4'h2,
        CMD_RD    = 4'h3,
        CMD_RDA   = 4'h4,
        CMD_MRRD  = 4'h5,
        CMD_MRWR  = 4'h6,
        CMD_WFIFO = 4'h7,
        CMD_RFIFO = 4'h8,
        CMD_RCAL  = 4'h9
    } wstt_cmd_t;
endpackage

// ===== wstt_ctrl.sv
// Host controller: spaces writes, reads and training commands and
// drives the write strobe pair. Assumes an AXI4-Lite master and a
// memory device on the pins; the memory clock is made here.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "wstt_defines.svh"
//Contract
//- BL16: wtr plus nRTP covers nWR
//- BL32: wtr plus nRTP plus 8 covers nWR
//- Strobe pair always clearly differential when driven
//- Two strobe modes: read based, window
//- Strobe logic never changes command spacing
//- Write to write FIFO gap enforced
//- Read to training gap enforced
//- Only mode writes and FIFO commands inside FIFO training
//- Read FIFO to write FIFO, no termination
//- Read FIFO to write FIFO, termination on
//- Write starts toggling from held level
//- Hold complement high after postamble
//- Strobes free while CKE low
//- Release strobe while device drives it
//- Window mode: drive from on to off
//- Skip window over read, bursts count
//- Strobe on delay from band table
//- Strobe off delay from band table
//- Exemption period after read to write
module wstt_ctrl #(
    parameter int CK_DIV = 4,
    parameter int AW     = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               mem_ck,
    output logic               mem_cke,
    output logic [3:0]         mem_cmd,
    output logic               mem_cmd_vld,
    output logic               dqs_t_lvl,
    output logic               dqs_c_lvl,
    output logic               dqs_oe,
    input  wire logic          dqs_t_sense,
    input  wire logic          dqs_c_sense
);
    // Memory clock period and the 7.5 ns floor in whole cycles, at least 8
    localparam int TCK_PS = CK_DIV * `WSTT_CLK_PS;
    localparam int N75 = (`WSTT_T75_PS + TCK_PS - 1) / TCK_PS;
    localparam int G75I = N75 > `WSTT_T75_MIN ? N75 : `WSTT_T75_MIN;
    localparam logic [9:0] G75 = 10'(G75I);
    localparam logic [47:0] TBL [16] = '{
        `WSTT_A0, `WSTT_A1, `WSTT_A2, `WSTT_A3,
        `WSTT_A4, `WSTT_A5, `WSTT_A6, `WSTT_A7,
        `WSTT_B0, `WSTT_B1, `WSTT_B2, `WSTT_B3,
        `WSTT_B4, `WSTT_B5, `WSTT_B6, `WSTT_B7};

    wstt_pkg::wstt_state_t st_reg, st_next;
    logic          awh_reg, awh_next, wh_reg, wh_next;
    logic [AW-1:0] awa_reg, awa_next;
    logic [31:0]   wd_reg, wd_next, rdat_reg, rdat_next;
    logic [3:0]    ws_reg, ws_next, cmd_reg, cmd_next;
    logic          bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0]    br_reg, br_next, rr_reg, rr_next;
    logic [7:0]    ctrl_reg, ctrl_next;
    logic [31:0]   skew_reg, skew_next;
    logic          ref_reg, ref_next, wfo_reg, wfo_next;
    logic          rfo_reg, rfo_next;
    logic [9:0]    ex_reg, ex_next;
    logic [7:0]    div_reg, div_next;
    logic          ck_reg, ck_next, cv_reg, cv_next;
    logic [3:0]    co_reg, co_next;
    logic          dt_reg, dt_next, dc_reg, dc_next;
    logic          oe_reg, oe_next;
    logic [1:0]    sy1_reg, sy1_next, sy2_reg, sy2_next;
    logic [47:0]   row;
    logic [9:0]    rl, wl, nwr, nrtp, son, soff, bl2;
    logic [9:0]    dqsck, dqss, rpst, wpre, odtl, odton, wtr, ta;
    logic [9:0]    g_wtt, g_rtt, g_rtw, g_wrc, g_wrd, g_wrda, wtr_eff;
    logic [9:0]    need [5];
    logic [4:0]    q, ok_v;
    logic          mode, bl32, odt, tick, issue, ok, win, exm;
    logic          any_burst, any_drv, any_own;
    wire  [4:0]    seen, burst, drv, own;
    wire  [7:0]    el [5];

    // Saturating subtract for cycle arithmetic
    function automatic logic [9:0] sub0(input logic [9:0] a,
                                        input logic [9:0] b);
        sub0 = (a > b) ? a - b : 10'h000;
    endfunction

    // One-hot class: write, read, write FIFO, read FIFO, read calib
    function automatic logic [4:0] cls_of(input logic [3:0] c);
        case (c)
            wstt_pkg::CMD_WR, wstt_pkg::CMD_MWR: cls_of = 5'h01;
            wstt_pkg::CMD_RD, wstt_pkg::CMD_RDA,
            wstt_pkg::CMD_MRRD: cls_of = 5'h02;
            wstt_pkg::CMD_WFIFO: cls_of = 5'h04;
            wstt_pkg::CMD_RFIFO: cls_of = 5'h08;
            wstt_pkg::CMD_RCAL: cls_of = 5'h10;
            default: cls_of = 5'h00;
        endcase
    endfunction

    // Forbidden orders and unknown codes
    function automatic logic bad(input logic [3:0] c, input logic wf,
                                 input logic rf);
        logic mrw, trn;
        mrw = (c == wstt_pkg::CMD_MRWR);
        trn = (c == wstt_pkg::CMD_WFIFO) || (c == wstt_pkg::CMD_RFIFO);
        bad = (cls_of(c) == 5'h00 && !mrw)
            || (wf && !(mrw || trn))
            || (!rf && c == wstt_pkg::CMD_RFIFO);
    endfunction

    // Field decode and band table lookup
    assign mode = ctrl_reg[`WSTT_C_MODE];
    assign bl32 = ctrl_reg[`WSTT_C_BL32];
    assign odt  = ctrl_reg[`WSTT_C_ODT];
    assign row  = TBL[{ctrl_reg[`WSTT_C_SETB],
                       ctrl_reg[`WSTT_C_BAND +: 3]}];
    assign rl   = {2'b00, row[`WSTT_F_RL +: 8]};
    assign wl   = {2'b00, row[`WSTT_F_WL +: 8]};
    assign nwr  = {2'b00, row[`WSTT_F_NWR +: 8]};
    assign nrtp = {2'b00, row[`WSTT_F_RTP +: 8]};
    // strobe on max delay per band
    assign son  = {2'b00, row[`WSTT_F_ON +: 8]};
    // strobe off min delay per band
    assign soff = {2'b00, row[`WSTT_F_OFF +: 8]};
    assign bl2  = bl32 ? `WSTT_BL2_32 : `WSTT_BL2_16;
    assign dqsck = {6'h00, skew_reg[`WSTT_S_DQSCK +: 4]};
    assign dqss  = {6'h00, skew_reg[`WSTT_S_DQSS +: 4]};
    assign rpst  = {6'h00, skew_reg[`WSTT_S_RPST +: 4]};
    assign wpre  = {6'h00, skew_reg[`WSTT_S_WPRE +: 4]};
    assign odtl  = {6'h00, skew_reg[`WSTT_S_ODTL +: 4]};
    assign odton = {6'h00, skew_reg[`WSTT_S_ODTON +: 4]};
    assign wtr   = {6'h00, skew_reg[`WSTT_S_WTR +: 4]};
    assign ta    = {6'h00, skew_reg[`WSTT_S_TA +: 4]};

    // Spacing figures in memory clock cycles
    // write to training gap
    assign g_wtt = wl + bl2 + dqss + G75;
    assign g_rtt = rl + dqsck + bl2 + rpst + G75;
    assign g_rtw = odt ? sub0(rl + dqsck + bl2 + rpst + 10'h001,
                              odtl + odton)
                       : sub0(rl + dqsck + bl2 + wpre + rpst, wl);
    assign g_wrc = wl + dqss + bl2 + wtr;
    assign g_wrd = wl + bl2 + wtr + 10'h001;
    // stretch so recovery ends before precharge
    assign wtr_eff = (wtr > sub0(sub0(nwr, nrtp),
                                 bl32 ? `WSTT_BL32_ADD : 10'h000))
                   ? wtr
                   : sub0(sub0(nwr, nrtp),
                          bl32 ? `WSTT_BL32_ADD : 10'h000);
    assign g_wrda = wl + bl2 + wtr_eff + 10'h001;

    // Gap needed after each earlier class for the pending command
    // every class counted before issue
    always_comb
    begin
        q = cls_of(cmd_reg);
        need[0] = q[2] ? g_wtt : q[4] ? g_wrc : q[1]
                ? ((cmd_reg == wstt_pkg::CMD_RDA) ? g_wrda : g_wrd)
                : 10'h000;
        need[1] = (q[2] || q[4]) ? g_rtt : q[0] ? g_rtw : 10'h000;
        need[2] = q[2] ? bl2 : q[3] ? g_wrc : 10'h000;
        need[3] = (q[0] || q[1] || q[4]) ? g_rtt : q[2] ? g_rtw
                : q[3] ? bl2 : 10'h000;
        need[4] = (q[0] || q[1] || q[2]) ? g_rtt : q[4] ? bl2
                : 10'h000;
        for (int i = 0; i < 5; i++)
            ok_v[i] = !seen[i] || ({2'b00, el[i]} >= need[i]);
    end
    assign tick  = (div_reg == 8'(CK_DIV - 1));
    assign ok    = &ok_v;
    // issue depends on state, tick and spacing, never on strobes
    assign issue = (st_reg == wstt_pkg::ST_WAIT) && tick && ok;

    // Per-class elapsed counters and strobe regions
    for (genvar i = 0; i < 5; i++)
    begin : g_cls
        localparam bit IS_W = (i == 0) || (i == 2);
        logic [7:0] e_reg, e_next;
        logic       s_reg, s_next;
        logic [9:0] w;
        always_comb
        begin
            e_next = e_reg;
            s_next = s_reg;
            if (tick && issue && q[i])
            begin
                e_next = 8'h01;
                s_next = 1'b1;
            end
            else if (tick && e_reg != `WSTT_SAT)
                e_next = e_reg + 8'h01;
        end
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                e_reg <= `WSTT_SAT;
                s_reg <= 1'b0;
            end
            else
            begin
                e_reg <= e_next;
                s_reg <= s_next;
            end
        end
        assign w = {2'b00, e_reg};
        assign el[i] = e_reg;
        assign seen[i] = s_reg;
        assign burst[i] = IS_W && s_reg && w >= wl && w < wl + bl2;
        assign drv[i] = IS_W && s_reg && w + wpre >= wl
                        && w <= wl + bl2;
        // device owns the strobe over read data
        assign own[i] = !IS_W && s_reg && w >= rl
                        && w < rl + dqsck + bl2 + rpst;
    end

    // Window and exemption state of the last write
    always_comb
    begin
        any_burst = |burst;
        any_drv   = |drv;
        any_own   = |own;
        exm = seen[0] && {2'b00, el[0]} < ex_reg;
        // drive from strobe on until strobe off
        win = seen[0] && {2'b00, el[0]} >= son
              && {2'b00, el[0]} < soff && !exm;
    end

    // Bus slave, control registers and command sequencer
    always_comb
    begin
        st_next = st_reg;     cmd_next = cmd_reg;
        awh_next = awh_reg;   wh_next = wh_reg;
        awa_next = awa_reg;   wd_next = wd_reg;
        ws_next = ws_reg;     bv_next = bv_reg;
        br_next = br_reg;     rv_next = rv_reg;
        rdat_next = rdat_reg; rr_next = rr_reg;
        ctrl_next = ctrl_reg; skew_next = skew_reg;
        ref_next = ref_reg;   wfo_next = wfo_reg;
        rfo_next = rfo_reg;   ex_next = ex_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awh_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wh_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (bv_reg && s_axi_bready)
            bv_next = 1'b0;
        if (awh_reg && wh_reg)
        begin
            awh_next = 1'b0;
            wh_next  = 1'b0;
            bv_next  = 1'b1;
            br_next  = `WSTT_RESP_OK;
            if (awa_reg == AW'(`WSTT_CTRL_OFF))
            begin
                if (ws_reg[0])
                    ctrl_next = wd_reg[7:0];
            end
            else if (awa_reg == AW'(`WSTT_SKEW_OFF))
            begin
                for (int b = 0; b < 4; b++)
                    if (ws_reg[b])
                        skew_next[8*b +: 8] = wd_reg[8*b +: 8];
            end
            else if (awa_reg == AW'(`WSTT_STAT_OFF))
            begin
                if (ws_reg[0] && wd_reg[`WSTT_ST_REF])
                    ref_next = 1'b0;
            end
            else if (awa_reg == AW'(`WSTT_CMD_OFF))
            begin
                if (ws_reg[0] && (st_reg != wstt_pkg::ST_IDLE
                    || bad(wd_reg[3:0], wfo_reg, rfo_reg)))
                    ref_next = 1'b1;
                else if (ws_reg[0])
                begin
                    cmd_next = wd_reg[3:0];
                    st_next  = wstt_pkg::ST_WAIT;
                end
            end
            else
                br_next = `WSTT_RESP_ERR;
        end
        if (rv_reg && s_axi_rready)
            rv_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_next = 1'b1;
            rr_next = `WSTT_RESP_OK;
            rdat_next = 32'h0000_0000;
            if (s_axi_araddr == AW'(`WSTT_CTRL_OFF))
                rdat_next[7:0] = ctrl_reg;
            else if (s_axi_araddr == AW'(`WSTT_SKEW_OFF))
                rdat_next = skew_reg;
            else if (s_axi_araddr == AW'(`WSTT_CMD_OFF))
                rdat_next[3:0] = cmd_reg;
            else if (s_axi_araddr == AW'(`WSTT_STAT_OFF))
                rdat_next[5:0] = {exm, sy2_reg, wfo_reg, ref_reg,
                                  st_reg == wstt_pkg::ST_WAIT};
            else
                rr_next = `WSTT_RESP_ERR;
        end
        if (issue)
        begin
            st_next = wstt_pkg::ST_IDLE;
            if (q[2])
            begin
                wfo_next = 1'b1;
                rfo_next = 1'b1;
            end
            if (q[3])
                wfo_next = 1'b0;
            if (q[0] || q[1] || q[4])
                rfo_next = 1'b0;
            // exemption after a read to write turn
            if (q[0])
                ex_next = !seen[1] ? 10'h000 : odt ? ta
                        : sub0(wl + ta, son + wpre
                               + sub0({2'b00, el[1]}, g_rtw));
        end
    end
    assign s_axi_awready = !awh_reg && !bv_reg;
    assign s_axi_wready  = !wh_reg && !bv_reg;
    assign s_axi_arready = !rv_reg;

    // Memory clock divider, command pins, strobe drive, synchroniser
    always_comb
    begin
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        ck_next  = div_next < 8'(CK_DIV / 2);
        co_next  = issue ? cmd_reg : co_reg;
        cv_next  = issue ? 1'b1 : (tick ? 1'b0 : cv_reg);
        sy1_next = {dqs_c_sense, dqs_t_sense};
        sy2_next = sy1_reg;
        // toggle in burst, otherwise complement held high
        dt_next  = any_burst ? ck_next : 1'b0;
        dc_next  = any_burst ? !ck_next : 1'b1;
        if (!mode)
            oe_next = !any_own;
        else
            oe_next = !any_own && (any_drv || win);
        oe_next = oe_next && ctrl_reg[`WSTT_C_CKE];
    end

    // Register all state except the per-class counters
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_reg <= wstt_pkg::ST_IDLE; cmd_reg <= 4'h0;
            awh_reg <= 1'b0;  wh_reg <= 1'b0;
            awa_reg <= '0;    wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;   bv_reg <= 1'b0;
            br_reg <= 2'h0;   rv_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000; rr_reg <= 2'h0;
            ctrl_reg <= `WSTT_CTRL_RST; skew_reg <= `WSTT_SKEW_RST;
            ref_reg <= 1'b0;  wfo_reg <= 1'b0;
            rfo_reg <= 1'b0;  ex_reg <= 10'h000;
            div_reg <= 8'h00; ck_reg <= 1'b0;
            cv_reg <= 1'b0;   co_reg <= 4'h0;
            dt_reg <= 1'b0;   dc_reg <= 1'b0;
            oe_reg <= 1'b0;   sy1_reg <= 2'h0;
            sy2_reg <= 2'h0;
        end
        else
        begin
            st_reg <= st_next;   cmd_reg <= cmd_next;
            awh_reg <= awh_next; wh_reg <= wh_next;
            awa_reg <= awa_next; wd_reg <= wd_next;
            ws_reg <= ws_next;   bv_reg <= bv_next;
            br_reg <= br_next;   rv_reg <= rv_next;
            rdat_reg <= rdat_next; rr_reg <= rr_next;
            ctrl_reg <= ctrl_next; skew_reg <= skew_next;
            ref_reg <= ref_next; wfo_reg <= wfo_next;
            rfo_reg <= rfo_next; ex_reg <= ex_next;
            div_reg <= div_next; ck_reg <= ck_next;
            cv_reg <= cv_next;   co_reg <= co_next;
            dt_reg <= dt_next;   dc_reg <= dc_next;
            oe_reg <= oe_next;   sy1_reg <= sy1_next;
            sy2_reg <= sy2_next;
        end
    end
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp  = br_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata  = rdat_reg;
    assign s_axi_rresp  = rr_reg;
    assign mem_ck      = ck_reg;
    assign mem_cke     = ctrl_reg[`WSTT_C_CKE];
    assign mem_cmd     = co_reg;
    assign mem_cmd_vld = cv_reg;
    assign dqs_t_lvl   = dt_reg;
    assign dqs_c_lvl   = dc_reg;
    assign dqs_oe      = oe_reg;

    // Checks on spacing and strobe drive
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wr_rda_gap: assert property (
        issue && cmd_reg == wstt_pkg::CMD_RDA && seen[0] |->
        {2'b00, el[0]} + nrtp + (bl32 ? `WSTT_BL32_ADD : 10'h000)
        >= wl + bl2 + 10'h001 + nwr)
        else $error("write recovery not covered before auto precharge");
    a_diff_level: assert property (
        dqs_oe |-> dqs_t_lvl != dqs_c_lvl)
        else $error("strobe driven without differential level");
    a_wtt_gap: assert property (
        issue && q[2] && seen[0] |-> {2'b00, el[0]} >= g_wtt)
        else $error("write FIFO training too soon after write");
    a_rtt_gap: assert property (
        issue && q[4] && seen[1] |-> {2'b00, el[1]} >= g_rtt)
        else $error("read calibration too soon after read");
    a_train_only: assert property (
        issue && wfo_reg |-> cmd_reg == wstt_pkg::CMD_MRWR
        || cmd_reg == wstt_pkg::CMD_WFIFO
        || cmd_reg == wstt_pkg::CMD_RFIFO)
        else $error("illegal command inside FIFO training");
    a_rtw_plain: assert property (
        issue && q[2] && seen[3] && !odt |-> {2'b00, el[3]} + wl
        >= rl + dqsck + bl2 + wpre + rpst)
        else $error("read FIFO to write FIFO gap too short");
    a_burst_toggle: assert property (
        !mode && mem_cke && any_burst && !any_own |=>
        dqs_oe && dqs_t_lvl == mem_ck)
        else $error("strobe not toggling with memory clock");
    a_hold_c_high: assert property (
        !mode && mem_cke && !any_burst && !any_own |=>
        dqs_oe && dqs_c_lvl && !dqs_t_lvl)
        else $error("complement strobe not held high");
    a_cke_low_free: assert property (
        !mem_cke ##1 !mem_cke |-> !dqs_oe)
        else $error("strobe driven while CKE low");
    a_read_release: assert property (
        any_own |=> !dqs_oe)
        else $error("strobe driven during read ownership");
    a_win_float: assert property (
        mode && !any_drv && !win |=> !dqs_oe)
        else $error("strobe driven outside window");
endmodule

// ===== wstt_dev.sv
// Far side model: the memory device's strobe pins.
// Assumes the controller's clock paces the released-line pattern.
`timescale 1ns/1ns
module wstt_dev (
    input  wire logic clk,
    input  wire logic mem_cke,
    input  wire logic dqs_oe,
    input  wire logic dqs_t_lvl,
    input  wire logic dqs_c_lvl,
    output logic      dqs_t_sense,
    output logic      dqs_c_sense
);
    logic pat_reg = 1'b0;
    // Released pins wander every cycle
    always_ff @(posedge clk)
        pat_reg <= ~pat_reg;
    // strobe state ignored unless driven with CKE high
    // Pins show the driven pair, or noise when released or CKE low
    assign dqs_t_sense = (dqs_oe && mem_cke) ? dqs_t_lvl : pat_reg;
    assign dqs_c_sense = (dqs_oe && mem_cke) ? dqs_c_lvl : ~pat_reg;
endmodule

// ===== write_strobe_training_timing_tb.sv
// Bench for the strobe and training spacing controller.
// Assumes the device model on the strobe pins.
`timescale 1ns/1ns
module write_strobe_training_timing_tb;
    localparam int CKD = 4;
    logic        clk = 1'b0, rst_n = 1'b0, vld_d = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, ck, cke, vld;
    logic        t_lvl, c_lvl, oe, t_sn, c_sn, b;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  mcmd;
    logic [7:0]  ctl;
    logic [65:0] e, qr[$];
    logic [15:0] f, qc[$];
    logic [1:0]  qb[$];
    int          n_fail = 0, comparisons = 0, cyc = 0, last = 0, bl2;
    wstt_ctrl #(.CK_DIV(CKD)) wstt_ctrl_inst (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mem_ck(ck), .mem_cke(cke), .mem_cmd(mcmd),
        .mem_cmd_vld(vld), .dqs_t_lvl(t_lvl), .dqs_c_lvl(c_lvl),
        .dqs_oe(oe), .dqs_t_sense(t_sn), .dqs_c_sense(c_sn));
    wstt_dev wstt_dev_inst (.clk(clk), .mem_cke(cke), .dqs_oe(oe),
        .dqs_t_lvl(t_lvl), .dqs_c_lvl(c_lvl), .dqs_t_sense(t_sn),
        .dqs_c_sense(c_sn));
    // Clock at 20 MHz
    initial
        forever #25 clk = ~clk;
    task give_verdict();
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        qb.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] m, x, input logic [1:0] r);
        qr.push_back({r, m, x});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // Issue one command and note its code and spacing in memory cycles
    task cmd(input logic [3:0] c, input int gap);
        qc.push_back({gap[11:0], c});
        wr(5'h08, {28'h0, c}, 2'h0);
        do @(posedge clk); while (!vld);
        repeat (CKD) @(posedge clk);
    endtask
    // Watcher: takes the oldest note for each answer or command issue
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        vld_d <= vld;
        if (bvalid && bready) chk(bresp, qb.pop_front());
        if (rvalid && rready)
        begin
            e = qr.pop_front();
            chk(rdata & e[63:32], e[31:0]);
            chk(rresp, e[65:64]);
        end
        if (vld && !vld_d)
        begin
            f = qc.pop_front();
            chk({mcmd, ck}, {f[3:0], 1'b1});
            if (f[15:4] != 0) chk(cyc - last, f[15:4] * CKD);
            last = cyc;
        end
        // Ceiling on run length; counts as a mismatch
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    // Main sequence
    initial
    begin
        void'($urandom(55754));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(5'h00, 32'hFFFF_FFFF, 32'h0, 2'h0);
        rd(5'h04, 32'hFFFF_FFFF, 32'h1412_2012, 2'h0);
        rd(5'h10, 32'hFFFF_FFFF, 32'h0, 2'h2);
        wr(5'h14, 32'h0, 2'h2);
        b = $urandom_range(0, 1);
        bl2 = b ? 16 : 8;
        ctl = {2'b10, 3'h7, 1'b0, b, 1'b0};
        wr(5'h00, {24'h0, ctl}, 2'h0);
        rd(5'h00, 32'hFFFF_FFFF, {24'h0, ctl}, 2'h0);
        repeat (8) @(posedge clk);
        chk({cke, oe, t_lvl, c_lvl}, 32'hD);
        cmd(wstt_pkg::CMD_WR, 0);
        cmd(wstt_pkg::CMD_WFIFO, 27 + bl2);
        cmd(wstt_pkg::CMD_RFIFO, 23 + bl2);
        cmd(wstt_pkg::CMD_WR, 46 + bl2);
        cmd(wstt_pkg::CMD_RDA, 19 + bl2 + (b ? 16 : 24));
        wr(5'h08, {28'h0, wstt_pkg::CMD_RFIFO}, 2'h0);
        rd(5'h0C, 32'h3F, 32'h12, 2'h0);
        wr(5'h0C, 32'h2, 2'h0);
        rd(5'h0C, 32'h3F, 32'h10, 2'h0);
        wr(5'h00, {24'h0, ctl & 8'h7F}, 2'h0);
        repeat (4) @(posedge clk);
        chk({cke, oe}, 32'h0);
        // Window mode, training with termination off then on
        wr(5'h00, {24'h0, ctl | 8'h01}, 2'h0);
        repeat (4) @(posedge clk);
        chk(oe, 32'h0);
        cmd(wstt_pkg::CMD_RCAL, 46 + bl2);
        cmd(wstt_pkg::CMD_WFIFO, 46 + bl2);
        cmd(wstt_pkg::CMD_MRWR, 0);
        cmd(wstt_pkg::CMD_RFIFO, 0);
        cmd(wstt_pkg::CMD_WFIFO, 22 + bl2);
        cmd(wstt_pkg::CMD_RFIFO, 23 + bl2);
        wr(5'h00, {24'h0, ctl | 8'h05}, 2'h0);
        cmd(wstt_pkg::CMD_WFIFO, 36 + bl2);
        cmd(wstt_pkg::CMD_RFIFO, 23 + bl2);
        cmd(wstt_pkg::CMD_WR, 46 + bl2);
        chk(oe, 32'h0);
        repeat (40) @(posedge clk);
        chk(oe, 32'h1);
        give_verdict();
    end
endmodule
